// ### rtl/tmc_timers.sv
/*
  Quad 16-bit counter/timer block with APB register access.
  Assumes a single APB master on pclk; event pins, external and RTC
  clocks and comparator outputs are asynchronous to pclk.
*/
// The register addresses and register access over APB were decided locally.
// Notes on behaviour
// - Four 16-bit timers: two legacy timers and two auto-reload timers.
// - Timers 0 and 1: 13-bit, 16-bit and 8-bit auto-reload modes; timer 0 also has split mode.
// - Split mode into two 8-bit timers exists only on timer 0.
// - Timers 2 and 3: one 16-bit reload timer or two 8-bit reload timers.
// - Timer 2 captures RTC/8 or comparator 0 period, timer 3 external clock/8 or comparator 1 period, in counts.
// - Timers 0 and 1 pick one of five clocks via select bits.
// - Each of timers 0/1 runs from the prescaled clock or system clock.
// - Timers 2 and 3 run from system clock or system clock over 12.
// - Timer 2 can also use RTC clock over 8 or comparator 0.
// - Timer 3 can also use external clock over 8 or comparator 1.
// - In counter mode each falling pin edge adds one to the count.
// - Pin events up to a quarter of the system clock are counted.
// - Timer overflows raise interrupt requests.
// - Prescale 00 /12, 01 /4, 10 /48, 11 external clock /8.
// - 13-bit wrap from all ones sets overflow and requests interrupt.
// - Counter select one counts pin edges, zero uses internal clock.
module tmc_timers (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        timer0_event_pin,
  input  wire logic        timer1_event_pin,
  input  wire logic        ext_osc_clk,
  input  wire logic        rtc_clk,
  input  wire logic        comparator0,
  input  wire logic        comparator1,
  output logic             irq
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  localparam int unsigned NUM_ST_W = tmc_pkg::NUM_ST;

  logic [3:0]  run_ff;
  logic [7:0]  mode_ff;
  logic [7:0]  clk_ff;
  logic [15:0] x23_ff;
  logic [15:0] cnt01_ff [2];
  logic [15:0] nxt_cnt01 [2];
  logic [15:0] cnt23_ff [2];
  logic [15:0] nxt_cnt23 [2];
  logic [15:0] rld23_ff [2];
  logic [NUM_ST_W-1:0] stat_ff;
  logic [NUM_ST_W-1:0] mask_ff;
  logic [NUM_ST_W-1:0] ev;
  logic [NUM_ST_W-1:0] clr;
  logic [31:0] prdata_ff;
  logic [5:0]  pin_rise;
  logic [5:0]  pin_fall;
  logic [1:0]  ovf_lo;
  logic [1:0]  ovf_hi;
  logic [1:0]  ev23_lo;
  logic [1:0]  ev23_hi;
  logic [1:0]  cap_hit;
  logic [1:0]  cmp_rise;
  logic        pre_tick;
  logic        wr;
  logic        setup;
  logic        rd_stat;

  tmc_tick_if ticks ();

  // ------------------------------------------------------------
  // Input synchronisers and prescaler
  // ------------------------------------------------------------
  tmc_sync_edge #(
    .W (6)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({comparator1, comparator0, rtc_clk, ext_osc_clk, timer1_event_pin, timer0_event_pin}),
    .rise     (pin_rise),
    .fall     (pin_fall)
  );

  tmc_prescale u_pre (
    .pclk     (pclk),
    .presetn  (presetn),
    .ext_rise (pin_rise[2]),
    .rtc_rise (pin_rise[3]),
    .ticks    (ticks.src)
  );

  assign cmp_rise = pin_rise[5:4];

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  function automatic logic is_mapped(input logic [7:0] a);
    case (a)
      tmc_pkg::OFF_RUN, tmc_pkg::OFF_MODE, tmc_pkg::OFF_CLK, tmc_pkg::OFF_T0,
      tmc_pkg::OFF_T1, tmc_pkg::OFF_X23, tmc_pkg::OFF_T2, tmc_pkg::OFF_R2,
      tmc_pkg::OFF_T3, tmc_pkg::OFF_R3, tmc_pkg::OFF_STAT, tmc_pkg::OFF_MASK:
        is_mapped = 1'b1;
      default:
        is_mapped = 1'b0;
    endcase
  endfunction

  function automatic logic hit(input logic [7:0] off);
    hit = psel && penable && pwrite && (paddr == off);
  endfunction

  assign wr      = psel && penable && pwrite;
  assign setup   = psel && !penable;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !is_mapped(paddr);
  assign prdata  = prdata_ff;
  assign rd_stat = psel && penable && !pwrite && (paddr == tmc_pkg::OFF_STAT);

  // Read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_ff <= tmc_pkg::RST_VAL;
    else if (setup && !pwrite)
    begin
      case (paddr)
        tmc_pkg::OFF_RUN:  prdata_ff <= {28'h0, run_ff};
        tmc_pkg::OFF_MODE: prdata_ff <= {24'h0, mode_ff};
        tmc_pkg::OFF_CLK:  prdata_ff <= {24'h0, clk_ff};
        tmc_pkg::OFF_T0:   prdata_ff <= {16'h0, cnt01_ff[0]};
        tmc_pkg::OFF_T1:   prdata_ff <= {16'h0, cnt01_ff[1]};
        tmc_pkg::OFF_X23:  prdata_ff <= {16'h0, x23_ff};
        tmc_pkg::OFF_T2:   prdata_ff <= {16'h0, cnt23_ff[0]};
        tmc_pkg::OFF_R2:   prdata_ff <= {16'h0, rld23_ff[0]};
        tmc_pkg::OFF_T3:   prdata_ff <= {16'h0, cnt23_ff[1]};
        tmc_pkg::OFF_R3:   prdata_ff <= {16'h0, rld23_ff[1]};
        tmc_pkg::OFF_STAT: prdata_ff <= {25'h0, stat_ff};
        tmc_pkg::OFF_MASK: prdata_ff <= {25'h0, mask_ff};
        default:           prdata_ff <= tmc_pkg::RST_VAL;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------
  // Run, mode, clock select, timer 2/3 config and mask
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run_ff  <= '0;
      mode_ff <= '0;
      clk_ff  <= '0;
      x23_ff  <= '0;
      mask_ff <= '0;
    end
    else
    begin
      if (hit(tmc_pkg::OFF_RUN))
        run_ff <= pwdata[3:0];
      if (hit(tmc_pkg::OFF_MODE))
        mode_ff <= pwdata[7:0];
      if (hit(tmc_pkg::OFF_CLK))
        clk_ff <= pwdata[7:0];
      if (hit(tmc_pkg::OFF_X23))
        x23_ff <= pwdata[15:0];
      if (hit(tmc_pkg::OFF_MASK))
        mask_ff <= pwdata[NUM_ST_W-1:0];
    end
  end

  // ------------------------------------------------------------
  // Timers 0 and 1
  // ------------------------------------------------------------
  // Shared prescaled clock
  always_comb
  begin
    case (tmc_pkg::tmc_pre_t'(clk_ff[tmc_pkg::PRE_LSB +: 2]))
      tmc_pkg::TMC_PRE12:  pre_tick = ticks.sys12;
      tmc_pkg::TMC_PRE4:   pre_tick = ticks.sys4;
      tmc_pkg::TMC_PRE48:  pre_tick = ticks.sys48;
      tmc_pkg::TMC_PREEXT: pre_tick = ticks.ext8;
      default:             pre_tick = 1'b0;
    endcase
  end

  for (genvar i = 0; i < 2; i++)
  begin : g_t01
    logic            ct;
    logic            sys_sel;
    logic            tick;
    logic            tick_hi;
    logic [12:0]     c13;
    tmc_pkg::tmc_mode_t mode;

    assign mode    = tmc_pkg::tmc_mode_t'(mode_ff[i*tmc_pkg::MODE_STRIDE +: 2]);
    assign ct      = mode_ff[i*tmc_pkg::MODE_STRIDE + tmc_pkg::CT_BIT];
    assign sys_sel = clk_ff[tmc_pkg::SYSSEL_LSB + i];
    // Pin edges, else system clock or prescaled clock
    assign tick    = run_ff[i] && (ct ? pin_fall[i] : (sys_sel || pre_tick));
    // Split high byte: timer only, gated by timer 1 run bit
    assign tick_hi = run_ff[1] && (sys_sel || pre_tick);
    assign c13     = {cnt01_ff[i][15:8], cnt01_ff[i][4:0]};

    // Next count per mode
    always_comb
    begin
      nxt_cnt01[i] = cnt01_ff[i];
      ovf_lo[i]    = 1'b0;
      ovf_hi[i]    = 1'b0;
      case (mode)
        tmc_pkg::TMC_M13:
          if (tick)
          begin
            nxt_cnt01[i] = {c13[12:5] + 8'(c13[4:0] == 5'h1f), cnt01_ff[i][7:5], c13[4:0] + 5'h01};
            ovf_lo[i]    = (c13 == tmc_pkg::CNT13_MAX);
          end
        tmc_pkg::TMC_M16:
          if (tick)
          begin
            nxt_cnt01[i] = cnt01_ff[i] + 16'h0001;
            ovf_lo[i]    = (cnt01_ff[i] == tmc_pkg::CNT16_MAX);
          end
        tmc_pkg::TMC_M8R:
          if (tick)
          begin
            if (cnt01_ff[i][7:0] == tmc_pkg::CNT8_MAX)
              nxt_cnt01[i][7:0] = cnt01_ff[i][15:8];
            else
              nxt_cnt01[i][7:0] = cnt01_ff[i][7:0] + 8'h01;
            ovf_lo[i] = (cnt01_ff[i][7:0] == tmc_pkg::CNT8_MAX);
          end
        tmc_pkg::TMC_SPLIT:
          if (i == 0)
          begin
            if (tick)
            begin
              nxt_cnt01[i][7:0] = cnt01_ff[i][7:0] + 8'h01;
              ovf_lo[i]         = (cnt01_ff[i][7:0] == tmc_pkg::CNT8_MAX);
            end
            if (tick_hi)
            begin
              nxt_cnt01[i][15:8] = cnt01_ff[i][15:8] + 8'h01;
              ovf_hi[i]          = (cnt01_ff[i][15:8] == tmc_pkg::CNT8_MAX);
            end
          end
        default:
          nxt_cnt01[i] = cnt01_ff[i];
      endcase
    end

    // Count register; software write wins over counting
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        cnt01_ff[i] <= '0;
      else if (hit(i == 0 ? tmc_pkg::OFF_T0 : tmc_pkg::OFF_T1))
        cnt01_ff[i] <= pwdata[15:0];
      else
        cnt01_ff[i] <= nxt_cnt01[i];
    end
  end

  // ------------------------------------------------------------
  // Timers 2 and 3
  // ------------------------------------------------------------
  for (genvar j = 0; j < 2; j++)
  begin : g_t23
    logic              split;
    logic              cap;
    logic              xtick;
    logic              tick_lo;
    logic              tick_hi;
    logic              cap_ev;
    logic              alt8;
    tmc_pkg::tmc_xsrc_t xs;

    assign split = x23_ff[j*tmc_pkg::X_STRIDE + tmc_pkg::SPLIT_BIT];
    assign cap   = x23_ff[j*tmc_pkg::X_STRIDE + tmc_pkg::CAP_BIT];
    assign xs    = tmc_pkg::tmc_xsrc_t'(x23_ff[j*tmc_pkg::X_STRIDE + tmc_pkg::XSRC_LSB +: 2]);
    assign alt8  = (j == 0) ? ticks.rtc8 : ticks.ext8;

    // Alternate clock source
    always_comb
    begin
      case (xs)
        tmc_pkg::TMC_X12:   xtick = ticks.sys12;
        tmc_pkg::TMC_XALT8: xtick = alt8;
        tmc_pkg::TMC_XCMP:  xtick = cmp_rise[j];
        default:            xtick = 1'b0;
      endcase
    end

    // In capture mode the measured source triggers the capture, the count clock is /12 or sysclk
    assign tick_lo = run_ff[2+j] && (clk_ff[tmc_pkg::ML_LSB + 2*j] || (cap ? ticks.sys12 : xtick));
    assign tick_hi = run_ff[2+j] && (clk_ff[tmc_pkg::ML_LSB + 2*j + 1] || xtick);
    assign cap_ev  = run_ff[2+j] && cap && (xs == tmc_pkg::TMC_XCMP ? cmp_rise[j] : alt8);

    // Next count per mode
    always_comb
    begin
      nxt_cnt23[j] = cnt23_ff[j];
      ev23_lo[j]   = 1'b0;
      ev23_hi[j]   = 1'b0;
      if (cap)
      begin
        if (tick_lo)
          nxt_cnt23[j] = cnt23_ff[j] + 16'h0001;
        ev23_hi[j] = cap_ev;
      end
      else if (split)
      begin
        if (tick_lo)
        begin
          ev23_lo[j] = (cnt23_ff[j][7:0] == tmc_pkg::CNT8_MAX);
          nxt_cnt23[j][7:0] = ev23_lo[j] ? rld23_ff[j][7:0] : cnt23_ff[j][7:0] + 8'h01;
        end
        if (tick_hi)
        begin
          ev23_hi[j] = (cnt23_ff[j][15:8] == tmc_pkg::CNT8_MAX);
          nxt_cnt23[j][15:8] = ev23_hi[j] ? rld23_ff[j][15:8] : cnt23_ff[j][15:8] + 8'h01;
        end
      end
      else if (tick_lo)
      begin
        ev23_hi[j] = (cnt23_ff[j] == tmc_pkg::CNT16_MAX);
        nxt_cnt23[j] = ev23_hi[j] ? rld23_ff[j] : cnt23_ff[j] + 16'h0001;
      end
    end

    assign cap_hit[j] = cap_ev;

    // Count register
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        cnt23_ff[j] <= '0;
      else if (hit(j == 0 ? tmc_pkg::OFF_T2 : tmc_pkg::OFF_T3))
        cnt23_ff[j] <= pwdata[15:0];
      else
        cnt23_ff[j] <= nxt_cnt23[j];
    end

    // Reload register, also the capture target
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        rld23_ff[j] <= '0;
      else if (cap_hit[j])
        rld23_ff[j] <= cnt23_ff[j];
      else if (hit(j == 0 ? tmc_pkg::OFF_R2 : tmc_pkg::OFF_R3))
        rld23_ff[j] <= pwdata[15:0];
    end
  end

  // ------------------------------------------------------------
  // Status, mask and interrupt
  // ------------------------------------------------------------
  // Event collection
  always_comb
  begin
    ev                     = '0;
    ev[tmc_pkg::ST_T0]     = ovf_lo[0];
    ev[tmc_pkg::ST_T1]     = ovf_lo[1];
    ev[tmc_pkg::ST_T0H]    = ovf_hi[0];
    ev[tmc_pkg::ST_T2H]    = ev23_hi[0];
    ev[tmc_pkg::ST_T2L]    = ev23_lo[0];
    ev[tmc_pkg::ST_T2H+2]  = ev23_hi[1];
    ev[tmc_pkg::ST_T2L+2]  = ev23_lo[1];
  end

  // Read clears only the bits that were returned
  assign clr = rd_stat ? prdata_ff[NUM_ST_W-1:0] : '0;

  // Sticky flags, a new event wins over the clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stat_ff <= '0;
    else
      stat_ff <= (stat_ff & ~clr) | ev;
  end

  assign irq = |(stat_ff & mask_ff);

endmodule

// ### rtl/tmc_pkg.sv
/*
  Constants and types shared by the quad timer block.
  Assumes a 32-bit APB slave with byte addresses on an 8-bit offset.
*/
package tmc_pkg;

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFF_RUN  = 8'h00;
  localparam logic [7:0] OFF_MODE = 8'h04;
  localparam logic [7:0] OFF_CLK  = 8'h08;
  localparam logic [7:0] OFF_T0   = 8'h0c;
  localparam logic [7:0] OFF_T1   = 8'h10;
  localparam logic [7:0] OFF_X23  = 8'h14;
  localparam logic [7:0] OFF_T2   = 8'h18;
  localparam logic [7:0] OFF_R2   = 8'h1c;
  localparam logic [7:0] OFF_T3   = 8'h20;
  localparam logic [7:0] OFF_R3   = 8'h24;
  localparam logic [7:0] OFF_STAT = 8'h28;
  localparam logic [7:0] OFF_MASK = 8'h2c;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int unsigned MODE_STRIDE = 4;  // Per timer 0/1 in mode register
  localparam int unsigned CT_BIT      = 2;  // Counter select within stride
  localparam int unsigned PRE_LSB     = 0;  // Prescale select in clock register
  localparam int unsigned SYSSEL_LSB  = 2;  // Timer 0/1 system clock selects
  localparam int unsigned ML_LSB      = 4;  // Timer 2/3 low/high clock selects
  localparam int unsigned X_STRIDE    = 8;  // Per timer 2/3 in x23 register
  localparam int unsigned SPLIT_BIT   = 0;
  localparam int unsigned CAP_BIT     = 1;
  localparam int unsigned XSRC_LSB    = 2;

  // Status bit positions
  localparam int unsigned ST_T0  = 0;
  localparam int unsigned ST_T1  = 1;
  localparam int unsigned ST_T0H = 2;
  localparam int unsigned ST_T2H = 3;
  localparam int unsigned ST_T2L = 4;
  localparam int unsigned NUM_ST = 7;

  // ------------------------------------------------------------
  // Divisors, limits, reset values
  // ------------------------------------------------------------
  localparam int unsigned DIV_SYS12 = 12;
  localparam int unsigned DIV_SYS4  = 4;
  localparam int unsigned DIV_SYS48 = 48;
  localparam int unsigned DIV_ALT8  = 8;
  localparam logic [12:0] CNT13_MAX = 13'h1fff;
  localparam logic [15:0] CNT16_MAX = 16'hffff;
  localparam logic [7:0]  CNT8_MAX  = 8'hff;
  localparam logic [31:0] RST_VAL   = 32'h0000_0000;

  // ------------------------------------------------------------
  // Modes and clock sources
  // ------------------------------------------------------------
  typedef enum logic [1:0] {TMC_M13, TMC_M16, TMC_M8R, TMC_SPLIT} tmc_mode_t;
  typedef enum logic [1:0] {TMC_PRE12, TMC_PRE4, TMC_PRE48, TMC_PREEXT} tmc_pre_t;
  typedef enum logic [1:0] {TMC_X12, TMC_XALT8, TMC_XCMP, TMC_XRSV} tmc_xsrc_t;

endpackage

// ### rtl/tmc_tick_if.sv
/*
  Tick bundle from the prescaler to the timers.
  Assumes every tick is a one-cycle pulse on pclk.
*/
interface tmc_tick_if;
  logic sys12;
  logic sys4;
  logic sys48;
  logic ext8;
  logic rtc8;

  modport src (output sys12, output sys4, output sys48, output ext8, output rtc8);
  modport dst (input sys12, input sys4, input sys48, input ext8, input rtc8);
endinterface

// ### rtl/tmc_sync_edge.sv
/*
  Two-flop synchroniser with edge detect for a group of async inputs.
  Assumes inputs hold each level for at least two pclk cycles.
*/
module tmc_sync_edge #(
  parameter int unsigned W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);

  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;

  // ------------------------------------------------------------
  // Sync chain, first flop feeds only the second
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end
    else
    begin
      s1_ff <= async_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // Edges from consecutive synced samples
  assign rise = s2_ff & ~s3_ff;
  assign fall = ~s2_ff & s3_ff;

endmodule

// ### rtl/tmc_prescale.sv
/*
  Prescaler: system clock divided by 12, 4 and 48, plus
  external and RTC clocks divided by 8 from their synced edges.
  Assumes ext_rise and rtc_rise are one-cycle pulses on pclk.
*/
module tmc_prescale #(
  parameter int unsigned DIV12 = tmc_pkg::DIV_SYS12,
  parameter int unsigned DIV4  = tmc_pkg::DIV_SYS4,
  parameter int unsigned DIV48 = tmc_pkg::DIV_SYS48,
  parameter int unsigned DIVA  = tmc_pkg::DIV_ALT8
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ext_rise,
  input  wire logic rtc_rise,
  tmc_tick_if.src   ticks
);

  localparam int unsigned DIVS [3] = '{DIV12, DIV4, DIV48};
  logic [2:0] sys_tick;
  logic [1:0] alt_tick;
  logic [1:0] alt_in;

  // ------------------------------------------------------------
  // System clock dividers
  // ------------------------------------------------------------
  for (genvar g = 0; g < 3; g++)
  begin : g_sys
    logic [7:0] cnt_ff;
    assign sys_tick[g] = (cnt_ff == 8'(DIVS[g] - 1));
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        cnt_ff <= '0;
      else if (sys_tick[g])
        cnt_ff <= '0;
      else
        cnt_ff <= cnt_ff + 8'h01;
    end
  end

  // ------------------------------------------------------------
  // Divide-by-8 of external and RTC edges
  // ------------------------------------------------------------
  assign alt_in = {rtc_rise, ext_rise};
  for (genvar a = 0; a < 2; a++)
  begin : g_alt
    logic [3:0] cnt_ff;
    assign alt_tick[a] = alt_in[a] && (cnt_ff == 4'(DIVA - 1));
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        cnt_ff <= '0;
      else if (alt_tick[a])
        cnt_ff <= '0;
      else if (alt_in[a])
        cnt_ff <= cnt_ff + 4'h1;
    end
  end

  assign ticks.sys12 = sys_tick[0];
  assign ticks.sys4  = sys_tick[1];
  assign ticks.sys48 = sys_tick[2];
  assign ticks.ext8  = alt_tick[0];
  assign ticks.rtc8  = alt_tick[1];

endmodule

// ### dv/tmc_timers_assertions.sv
/*
  Checker for the APB side and interrupt of the quad timer block.
  Assumes it is bound to tmc_timers and sees only its ports.
*/
module tmc_timers_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        timer0_event_pin,
  input wire logic        timer1_event_pin,
  input wire logic        ext_osc_clk,
  input wire logic        rtc_clk,
  input wire logic        comparator0,
  input wire logic        comparator1,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Zero wait states, error only on unmapped access
  AST_READY: assert property (pready) else $error("pready low");
  AST_ERR_PHASE: assert property (pslverr |-> psel && penable) else $error("pslverr outside access");
  AST_ERR_MAP: assert property (psel && penable && paddr > 8'h2c |-> pslverr) else $error("no pslverr");
  AST_OK_MAP: assert property (psel && penable && paddr <= 8'h2c && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("pslverr on mapped");
  AST_ERR_RD: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("unmapped read data");
  // Read data holds until the next read setup
  AST_PRD_HOLD: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata)) else $error("prdata moved");
  AST_RST: assert property ($rose(presetn) |-> !irq && prdata == 32'h0) else $error("reset state");
  AST_MASK0: assert property (psel && penable && pwrite && paddr == tmc_pkg::OFF_MASK && pwdata[6:0] == 7'h0
    |=> !irq) else $error("irq with mask clear");
endmodule

bind tmc_timers tmc_timers_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .timer0_event_pin(timer0_event_pin), .timer1_event_pin(timer1_event_pin), .ext_osc_clk(ext_osc_clk),
  .rtc_clk(rtc_clk), .comparator0(comparator0), .comparator1(comparator1), .irq(irq));

// ### dv/tmc_pin_model.sv
/*
  Far side: event pins, external and RTC clocks, comparators.
  Assumes the bench calls burst from one process at a time.
*/
module tmc_pin_model (
  input  wire logic       pclk,
  output logic      [5:0] lines
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [5:0] IDLE = 6'h03; // Pins rest high, clocks low

  initial lines = IDLE;

  // Pulses on one line, each level held hold cycles
  task automatic burst(input int ln, input int n, input int hold);
    repeat (n)
    begin
      @(posedge pclk);
      lines[ln] <= ~IDLE[ln];
      repeat (hold) @(posedge pclk);
      lines[ln] <= IDLE[ln];
      repeat (hold - 1) @(posedge pclk);
    end
  endtask
endmodule

// ### dv/tb.sv
/*
  Self-checking bench for tmc_timers with an APB master.
  Assumes the checker and pin model are compiled first.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic            pclk;
  logic            presetn;
  logic            psel;
  logic            penable;
  logic            pwrite;
  logic [7:0]      paddr;
  logic [31:0]     pwdata;
  logic [31:0]     prdata;
  logic            pready;
  logic            pslverr;
  logic            irq;
  wire logic [5:0] lines;
  logic [31:0]     rdv;
  logic            erv;
  int              err_count;
  int              checks;
  int              cyc;
  int              seed;

  tmc_timers u_tmc_timers (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer0_event_pin(lines[0]), .timer1_event_pin(lines[1]), .ext_osc_clk(lines[2]),
    .rtc_clk(lines[3]), .comparator0(lines[4]), .comparator1(lines[5]), .irq(irq));
  tmc_pin_model u_tmc_pin_model (.pclk(pclk), .lines(lines));

  // Clock, 100 ns period
  always #50 pclk = ~pclk;

  // Cycle ceiling against hangs
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_count++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer, held until pready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'h1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1)
      @(posedge pclk);
    rdv = prdata;
    erv = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'h1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    xfer(1'h0, a, 32'h0);
  endtask

  // Count gained over 192 cycles, or over n events on line ln
  task automatic meas(input logic [7:0] ck, input logic [15:0] x, input logic [7:0] md, input logic [7:0] rn,
                      input logic [7:0] off, input int ln, input int n, input logic [15:0] exp);
    logic [15:0] a;
    if (n == 0)
    begin
      n = 1 + ($unsigned($random(seed)) % 20);
      exp = n[15:0];
    end
    wr(tmc_pkg::OFF_RUN, 32'h0);
    wr(off, $random(seed) & 32'hffff);
    wr(tmc_pkg::OFF_CLK, {24'h0, ck});
    wr(tmc_pkg::OFF_X23, {16'h0, x});
    wr(tmc_pkg::OFF_MODE, {24'h0, md});
    wr(tmc_pkg::OFF_RUN, {24'h0, rn});
    rd(off);
    a = rdv[15:0];
    if (ln > 5)
      repeat (189) @(posedge pclk);
    else
    begin
      u_tmc_pin_model.burst(ln, n, 2 + ($unsigned($random(seed)) % 2));
      repeat (5) @(posedge pclk);
    end
    rd(off);
    chk("delta", {17'h0, rdv[15:0] - a}, {17'h0, exp});
  endtask

  // Main sequence
  initial
  begin
    seed = 79087;
    pclk = 1'h0;
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    err_count = 0;
    checks = 0;
    cyc = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    for (int i = 0; i < 12; i++)
    begin
      rd(8'(4 * i));
      chk("reset value", {erv, rdv}, 33'h0);
    end
    rd(8'h30 + 8'(($unsigned($random(seed)) % 52) * 4));
    chk("unmapped", {erv, rdv}, 33'h1_0000_0000);
    // 13-bit wrap sets the flag and, once unmasked, the interrupt
    wr(tmc_pkg::OFF_MASK, 32'h0);
    wr(tmc_pkg::OFF_MODE, 32'h4);
    wr(tmc_pkg::OFF_T0, 32'hff1f);
    rd(tmc_pkg::OFF_STAT);
    wr(tmc_pkg::OFF_RUN, 32'h1);
    u_tmc_pin_model.burst(0, 1, 2);
    repeat (5) @(posedge pclk);
    chk("irq masked", {32'h0, irq}, 33'h0);
    wr(tmc_pkg::OFF_MASK, 32'h1);
    @(posedge pclk);
    chk("irq", {32'h0, irq}, 33'h1);
    rd(tmc_pkg::OFF_T0);
    chk("wrap", {erv, rdv}, 33'h0);
    rd(tmc_pkg::OFF_STAT);
    chk("status", {erv, rdv}, 33'h1);
    rd(tmc_pkg::OFF_STAT);
    chk("status cleared", {erv, rdv}, 33'h0);
    chk("irq cleared", {32'h0, irq}, 33'h0);
    wr(tmc_pkg::OFF_MODE, 32'h6);
    wr(tmc_pkg::OFF_T0, 32'h40ff);
    u_tmc_pin_model.burst(0, 1, 2);
    rd(tmc_pkg::OFF_T0);
    chk("reload", {erv, rdv}, 33'h4040);
    // Clock sources, counter inputs and modes
    meas(8'h00, 16'h0, 8'h01, 8'h1, tmc_pkg::OFF_T0, 9, 1, 16'h10);
    meas(8'h01, 16'h0, 8'h01, 8'h1, tmc_pkg::OFF_T0, 9, 1, 16'h30);
    meas(8'h02, 16'h0, 8'h01, 8'h1, tmc_pkg::OFF_T0, 9, 1, 16'h04);
    meas(8'h04, 16'h0, 8'h01, 8'h1, tmc_pkg::OFF_T0, 9, 1, 16'hc0);
    meas(8'h03, 16'h0, 8'h10, 8'h2, tmc_pkg::OFF_T1, 2, 16, 16'h2);
    meas(8'h08, 16'h0, 8'h10, 8'h2, tmc_pkg::OFF_T1, 9, 1, 16'hc0);
    meas(8'h08, 16'h0, 8'h30, 8'h2, tmc_pkg::OFF_T1, 9, 1, 16'h0);
    meas(8'h04, 16'h0, 8'h03, 8'h2, tmc_pkg::OFF_T0, 9, 1, 16'hc000);
    meas(8'h04, 16'h0, 8'h05, 8'h1, tmc_pkg::OFF_T0, 0, 0, 16'h0);
    meas(8'h00, 16'h0, 8'h50, 8'h2, tmc_pkg::OFF_T1, 1, 0, 16'h0);
    meas(8'h10, 16'h0, 8'h00, 8'h4, tmc_pkg::OFF_T2, 9, 1, 16'hc0);
    meas(8'h00, 16'h0, 8'h00, 8'h4, tmc_pkg::OFF_T2, 9, 1, 16'h10);
    meas(8'h00, 16'h4, 8'h00, 8'h4, tmc_pkg::OFF_T2, 3, 16, 16'h2);
    meas(8'h00, 16'h8, 8'h00, 8'h4, tmc_pkg::OFF_T2, 4, 0, 16'h0);
    meas(8'h20, 16'hd, 8'h00, 8'h4, tmc_pkg::OFF_T2, 9, 1, 16'hc000);
    meas(8'h40, 16'h0, 8'h00, 8'h8, tmc_pkg::OFF_T3, 9, 1, 16'hc0);
    meas(8'h00, 16'h400, 8'h00, 8'h8, tmc_pkg::OFF_T3, 2, 16, 16'h2);
    meas(8'h00, 16'h800, 8'h00, 8'h8, tmc_pkg::OFF_T3, 5, 0, 16'h0);
    // Capture on comparator 0
    wr(tmc_pkg::OFF_T2, 32'h0);
    wr(tmc_pkg::OFF_CLK, 32'h10);
    wr(tmc_pkg::OFF_X23, 32'ha);
    wr(tmc_pkg::OFF_RUN, 32'h4);
    u_tmc_pin_model.burst(4, 1, 2);
    rd(tmc_pkg::OFF_R2);
    chk("capture", {erv, rdv}, 33'h3);
    report_and_stop();
  end
endmodule
